// ### hw/adcsq_pkg.sv
// package: constants and types for the converter sequencer
package adcsq_pkg;
  localparam int ADCSQ_RES_W = 10;
  localparam int ADCSQ_SEL_W = 6;
  localparam int ADCSQ_NUM_SRC = 34;
  localparam int ADCSQ_CLK_HZ = 40000000;
  // one instruction cycle, in nanoseconds
  localparam int ADCSQ_INSTR_NS = 100;
  localparam int ADCSQ_INSTR_CYC = (ADCSQ_INSTR_NS * (ADCSQ_CLK_HZ / 1000000) + 999) / 1000;
  // one bit decision per converter clock, in nanoseconds
  localparam int ADCSQ_BIT_NS = 1000;
  localparam int ADCSQ_BIT_CYC = (ADCSQ_BIT_NS * (ADCSQ_CLK_HZ / 1000000)) / 1000;
  localparam logic [9:0] ADCSQ_RES_RST = 10'h000;
  localparam logic [5:0] ADCSQ_SEL_RST = 6'h00;
  localparam int ADCSQ_HIGH_LSB = 8;

  // control bits from software
  typedef struct packed {
    logic converter_on;
    logic go_set;
    logic go_clear;
    logic dedicated_rc_clock;
    logic int_enable;
    logic sleep;
    logic [5:0] trigger_select;
  } adcsq_ctrl_t;

  // status back to software
  typedef struct packed {
    logic converter_on;
    logic go;
    logic conversion_done_flag;
    logic active;
    logic wake;
    logic [7:0] result_high;
    logic [7:0] result_low;
  } adcsq_stat_t;
endpackage

// ### hw/adcsq_trig_sel.sv
// trigger source selection and rising edge detect
`timescale 1ns/1ps
module adcsq_trig_sel
  import adcsq_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [ADCSQ_NUM_SRC-1:0] i_src,
  input wire logic [5:0] i_sel,
  output logic o_rise
);
  logic [ADCSQ_NUM_SRC-1:0] meta_q;
  logic [ADCSQ_NUM_SRC-1:0] sync_q;
  logic sel_q;
  logic pick_d;

  // sources may be asynchronous, so two flops first
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_src;
      sync_q <= meta_q;
    end
  end

  // codes beyond the table select nothing
  always_comb begin
    pick_d = 1'b0;
    if (i_sel < 6'(ADCSQ_NUM_SRC)) begin
      pick_d = sync_q[i_sel];
    end
  end

  // previous selected level; a select change can give one false edge
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sel_q <= 1'b0;
    end else begin
      sel_q <= pick_d;
    end
  end

  assign o_rise = pick_d & ~sel_q;
endmodule

// ### hw/adcsq_sar.sv
// successive approximation bit stepper with partial fill
`timescale 1ns/1ps
module adcsq_sar
  import adcsq_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_start,
  input wire logic i_stop,
  input wire logic i_cmp,
  output logic o_busy,
  output logic o_last,
  output logic [9:0] o_code
);
  logic [9:0] code_q;
  logic [3:0] bit_q;
  logic [7:0] tick_q;
  logic busy_q;

  // bit index counts down; tick paces each decision
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      busy_q <= 1'b0;
      bit_q <= 4'h0;
      tick_q <= 8'h00;
      code_q <= ADCSQ_RES_RST;
    end else if (i_stop) begin
      busy_q <= 1'b0;
    end else if (i_start) begin
      busy_q <= 1'b1;
      bit_q <= 4'(ADCSQ_RES_W - 1);
      tick_q <= 8'h00;
      code_q <= ADCSQ_RES_RST;
    end else if (busy_q) begin
      if (tick_q == 8'(ADCSQ_BIT_CYC - 1)) begin
        tick_q <= 8'h00;
        code_q[bit_q] <= i_cmp;
        if (bit_q == 4'h0) begin
          busy_q <= 1'b0;
        end else begin
          bit_q <= bit_q - 4'h1;
        end
      end else begin
        tick_q <= tick_q + 8'h01;
      end
    end
  end

  assign o_busy = busy_q;
  assign o_last = busy_q && bit_q == 4'h0 && tick_q == 8'(ADCSQ_BIT_CYC - 1);
  assign o_code = code_q;

  // partial code: unresolved bits copy the last resolved bit
  function automatic logic [9:0] fill(input logic [9:0] c, input logic [3:0] b);
    logic [9:0] r;
    r = c;
    for (int k = 0; k < ADCSQ_RES_W; k++) begin
      if (k <= int'(b)) begin
        r[k] = (b == 4'(ADCSQ_RES_W - 1)) ? 1'b0 : c[b + 4'h1];
      end
    end
    return r;
  endfunction

  logic [9:0] part_code;
  assign part_code = fill(code_q, bit_q);
endmodule

// ### hw/adcsq_top.sv
// converter conversion sequencer top
`timescale 1ns/1ps
module adcsq_top
  import adcsq_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire adcsq_ctrl_t i_ctrl,
  input wire logic i_done_flag_clr,
  input wire logic i_cmp,
  input wire logic [ADCSQ_NUM_SRC-1:0] i_trig_src,
  output adcsq_stat_t o_stat,
  output logic o_sample
);
  typedef enum logic [1:0] {ADCSQ_IDLE, ADCSQ_WAIT, ADCSQ_CONV} adcsq_state_t;

  adcsq_state_t state_q;
  logic go_q;
  logic done_q;
  logic on_q;
  logic off_q;
  logic wake_q;
  logic [9:0] res_q;
  logic [7:0] dly_q;
  logic [5:0] sel_q;
  logic trig_rise;
  logic start_conv;
  logic sar_busy;
  logic sar_last;
  logic [9:0] sar_code;
  logic [3:0] sar_bit;
  logic enabled;
  logic abort_sleep;
  logic sw_stop;
  logic complete;
  logic go_req;

  // the on bit stays readable even when sleep powers the module down
  assign enabled = on_q & ~off_q;
  assign abort_sleep = i_ctrl.sleep & ~i_ctrl.dedicated_rc_clock & state_q != ADCSQ_IDLE;
  assign sw_stop = i_ctrl.go_clear & state_q != ADCSQ_IDLE;
  assign complete = sar_last & state_q == ADCSQ_CONV;
  // go from software or trigger, only while enabled
  assign go_req = enabled & (i_ctrl.go_set | trig_rise);

  adcsq_trig_sel u_trig (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_src(i_trig_src),
    .i_sel(sel_q),
    .o_rise(trig_rise)
  );

  adcsq_sar u_sar (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_start(start_conv),
    .i_stop(sw_stop | abort_sleep | ~enabled),
    .i_cmp(i_cmp),
    .o_busy(sar_busy),
    .o_last(sar_last),
    .o_code(sar_code)
  );

  // bit index is tracked here too, for the partial fill
  logic [3:0] bit_q;
  logic [7:0] tick_q;
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      bit_q <= 4'h0;
      tick_q <= 8'h00;
    end else if (start_conv) begin
      bit_q <= 4'(ADCSQ_RES_W - 1);
      tick_q <= 8'h00;
    end else if (sar_busy) begin
      if (tick_q == 8'(ADCSQ_BIT_CYC - 1)) begin
        tick_q <= 8'h00;
        if (bit_q != 4'h0) begin
          bit_q <= bit_q - 4'h1;
        end
      end else begin
        tick_q <= tick_q + 8'h01;
      end
    end
  end
  assign sar_bit = bit_q;

  // unresolved bits take the last resolved bit's value
  function automatic logic [9:0] part_fill(input logic [9:0] c, input logic [3:0] b);
    logic [9:0] r;
    logic fillv;
    r = c;
    fillv = (b == 4'(ADCSQ_RES_W - 1)) ? 1'b0 : c[b + 4'h1];
    for (int k = 0; k < ADCSQ_RES_W; k++) begin
      if (k <= int'(b)) begin
        r[k] = fillv;
      end
    end
    return r;
  endfunction

  // converter_on and trigger select are software-owned levels
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      on_q <= 1'b0;
      sel_q <= ADCSQ_SEL_RST;
    end else begin
      on_q <= i_ctrl.converter_on;
      sel_q <= i_ctrl.trigger_select;
    end
  end

  // sleep power-down: cleared by software rewriting converter_on low
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      off_q <= 1'b0;
    end else if (~i_ctrl.converter_on) begin
      off_q <= 1'b0;
    end else if (abort_sleep) begin
      off_q <= 1'b1;
    end else if (complete & i_ctrl.sleep & ~i_ctrl.int_enable) begin
      off_q <= 1'b1;
    end
  end

  // sequencer: optional one instruction wait, then conversion
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_q <= ADCSQ_IDLE;
      dly_q <= 8'h00;
    end else if (sw_stop | abort_sleep | ~enabled) begin
      state_q <= ADCSQ_IDLE;
    end else begin
      unique case (state_q)
        ADCSQ_IDLE: begin
          if (go_req & i_ctrl.dedicated_rc_clock) begin
            state_q <= ADCSQ_WAIT;
            dly_q <= 8'h00;
          end else if (go_req) begin
            state_q <= ADCSQ_CONV;
          end
        end
        ADCSQ_WAIT: begin
          if (dly_q == 8'(ADCSQ_INSTR_CYC - 1)) begin
            state_q <= ADCSQ_CONV;
          end else begin
            dly_q <= dly_q + 8'h01;
          end
        end
        ADCSQ_CONV: begin
          if (complete) begin
            state_q <= ADCSQ_IDLE;
          end
        end
      endcase
    end
  end

  assign start_conv = (state_q == ADCSQ_IDLE & go_req & ~i_ctrl.dedicated_rc_clock)
    | (state_q == ADCSQ_WAIT & dly_q == 8'(ADCSQ_INSTR_CYC - 1) & enabled
       & ~sw_stop & ~abort_sleep);

  // go bit: set by request, cleared by completion, stop or abort
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      go_q <= 1'b0;
    end else if (go_req & state_q == ADCSQ_IDLE) begin
      go_q <= 1'b1;
    end else if (complete | sw_stop | abort_sleep | ~enabled) begin
      go_q <= 1'b0;
    end
  end

  // done flag: hardware set wins over software clear
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      done_q <= 1'b0;
    end else if (complete) begin
      done_q <= 1'b1;
    end else if (i_done_flag_clr) begin
      done_q <= 1'b0;
    end
  end

  // result load on completion or early stop; sleep abort leaves it
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      res_q <= ADCSQ_RES_RST;
    end else if (complete) begin
      res_q <= {sar_code[9:1], i_cmp};
    end else if (sw_stop & state_q == ADCSQ_CONV) begin
      res_q <= part_fill(sar_code, sar_bit);
    end
  end

  // wake pulse when a conversion ends in sleep with interrupt on
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= complete & i_ctrl.sleep & i_ctrl.int_enable;
    end
  end

  always_comb begin
    o_stat = '0;
    o_stat.converter_on = on_q;
    o_stat.go = go_q;
    o_stat.conversion_done_flag = done_q;
    o_stat.active = state_q != ADCSQ_IDLE;
    o_stat.wake = wake_q;
    o_stat.result_high = {6'h00, res_q[9:ADCSQ_HIGH_LSB]};
    o_stat.result_low = res_q[7:0];
  end
  assign o_sample = state_q == ADCSQ_CONV;

  a_go_needs_enable: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !enabled |=> state_q == ADCSQ_IDLE && !go_q) else $error("conversion while off");
  a_done_sets: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    complete |=> done_q && !go_q) else $error("completion not flagged");
  a_rc_delay: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state_q == ADCSQ_IDLE && go_req && i_ctrl.dedicated_rc_clock) |=> state_q == ADCSQ_WAIT)
    else $error("rc start not delayed");
  a_sleep_abort: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    abort_sleep |=> state_q == ADCSQ_IDLE && !go_q) else $error("sleep did not abort");
  a_stop_clears: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    sw_stop |=> !go_q) else $error("stop left go set");
  a_trig_go: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (trig_rise && enabled && state_q == ADCSQ_IDLE) |=> go_q) else $error("trigger lost");
  a_wake_pulse: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (complete && i_ctrl.sleep && i_ctrl.int_enable) |=> wake_q) else $error("no wake");
  a_off_keeps_on: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (complete && i_ctrl.sleep && !i_ctrl.int_enable && i_ctrl.converter_on) |=> off_q)
    else $error("module not powered down");

  // steps of a finished conversion: last decision, then flag up and go down
  sequence s_last_bit;
    complete;
  endsequence

  sequence s_result_up;
    done_q && !go_q && state_q == ADCSQ_IDLE;
  endsequence

  // steps of an early stop: request while converting, then stepper halted
  sequence s_stop_req;
    sw_stop && state_q == ADCSQ_CONV;
  endsequence

  sequence s_stop_seen;
    state_q == ADCSQ_IDLE && !go_q && !sar_busy;
  endsequence

  // steps of a hardware trigger: edge while idle, then a running conversion
  sequence s_trig_edge;
    trig_rise && enabled && state_q == ADCSQ_IDLE && !i_ctrl.dedicated_rc_clock;
  endsequence

  sequence s_trig_run;
    go_q && state_q == ADCSQ_CONV && sar_busy;
  endsequence

  // multi-step checks built from the sequences above
  a_end_steps: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s_last_bit |=> s_result_up) else $error("completion steps out of order");
  a_stop_steps: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s_stop_req |=> s_stop_seen) else $error("early stop not taken");
  a_trig_steps: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s_trig_edge |=> s_trig_run) else $error("trigger did not start");

  // held values: flag and result only move on their own events
  a_done_holds: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (done_q && !complete && !i_done_flag_clr) |=> done_q) else $error("done flag lost");
  a_result_holds: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!complete && !(sw_stop && state_q == ADCSQ_CONV)) |=> $stable(res_q))
    else $error("result changed without a load");

  // rc wait never overruns one instruction and then converts unless stopped, aborted or disabled
  a_wait_bound: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    state_q == ADCSQ_WAIT |-> dly_q < 8'(ADCSQ_INSTR_CYC)) else $error("wait overran");
  a_rc_starts: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state_q == ADCSQ_WAIT && dly_q == 8'(ADCSQ_INSTR_CYC - 1) && enabled && !sw_stop
     && !abort_sleep) |=> state_q == ADCSQ_CONV && sar_busy) else $error("rc start lost");

  // wake only ever follows a completion in sleep with interrupt on
  a_wake_cause: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    wake_q |-> $past(complete && i_ctrl.sleep && i_ctrl.int_enable))
    else $error("spurious wake");
  a_sel_follows: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    1'b1 |=> sel_q == $past(i_ctrl.trigger_select)) else $error("select not taken");
endmodule

// ### verification/adcsq_cmp_model.sv
// comparator stand-in for the converter's analog side
`timescale 1ns/1ps
module adcsq_cmp_model
  import adcsq_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sample,
  input wire logic [9:0] i_level,
  output logic o_cmp
);
  int cnt = 0;
  int bitn;
  logic tog = 1'b0;
  // count cycles of the running conversion, one bit per bit time
  always @(posedge i_clk) begin
    cnt <= i_sample ? cnt + 1 : 0;
    tog <= ~tog;
  end
  assign bitn = cnt / ADCSQ_BIT_CYC;
  // msb first; idle output toggles so no stale level can be leaned on
  always_comb begin
    if (i_sample && bitn < 10) begin
      o_cmp = i_level[9 - bitn];
    end else begin
      o_cmp = tog;
    end
  end
endmodule

// ### verification/adc_conversion_sequencer_test.sv
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
module adc_conversion_sequencer_test
  import adcsq_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clr = 1'b0;
  logic cmp;
  logic smp;
  logic woke = 1'b0;
  logic [33:0] trig = 34'h0;
  adcsq_ctrl_t c = '0;
  adcsq_stat_t st;
  int failures = 0;
  int checked = 0;
  int n;

  adcsq_top u_dut (.i_clk(clk), .i_sys_rst(rst), .i_ctrl(c), .i_done_flag_clr(clr),
    .i_cmp(cmp), .i_trig_src(trig), .o_stat(st), .o_sample(smp));
  // level 2C5 keeps bits 7 and 6 equal, so a cut in bit 6 reads alike
  adcsq_cmp_model u_cmp (.i_clk(clk), .i_sample(smp), .i_level(10'h2C5), .o_cmp(cmp));

  // clock and wake pulse catcher
  initial begin
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (st.wake === 1'b1) woke <= 1'b1;
  end

  task automatic results();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // software go write, one cycle wide
  task automatic go();
    c.go_set = 1'b1;
    tick(1);
    c.go_set = 1'b0;
  endtask
  // bounded wait for the done flag, then clear it
  task automatic wait_done();
    n = 0;
    while (st.conversion_done_flag !== 1'b1 && n < 2000) begin
      tick(1);
      n++;
    end
    if (n >= 2000) begin
      failures++;
      results();
    end
    clr = 1'b1;
    tick(1);
    clr = 1'b0;
  endtask
  // enable first, go two cycles later
  task automatic power_up(input logic rc);
    c = '0;
    c.dedicated_rc_clock = rc;
    c.converter_on = 1'b1;
    tick(2);
  endtask

  task automatic t_full();
    power_up(1'b0);
    go();
    chk(st.go, 1);
    wait_done();
    chk(n, ADCSQ_RES_W * ADCSQ_BIT_CYC);
    chk(st.go, 0);
    chk({st.result_high, st.result_low}, 16'h02C5);
    $display("full conversion done");
  endtask
  task automatic t_off();
    c = '0;
    tick(2);
    go();
    tick(2);
    chk({st.go, smp}, 0);
    $display("disabled go done");
  endtask
  task automatic t_stop();
    power_up(1'b0);
    go();
    tick(140);
    c.go_clear = 1'b1;
    tick(1);
    c.go_clear = 1'b0;
    tick(3);
    chk({st.go, smp}, 0);
    chk({st.result_high, st.result_low}, 16'h02FF);
    $display("early stop done");
  endtask
  task automatic t_rc(input logic ie);
    power_up(1'b1);
    c.int_enable = ie;
    woke = 1'b0;
    go();
    n = 0;
    while (smp !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    chk(n, ADCSQ_INSTR_CYC);
    c.sleep = 1'b1;
    wait_done();
    tick(2);
    chk(woke, ie);
    chk({st.converter_on, st.active}, 2'h2);
    go();
    chk(st.go, ie);
    c = '0;
    tick(2);
    $display("rc sleep done");
  endtask
  task automatic t_sleep_abort();
    power_up(1'b0);
    go();
    tick(50);
    c.sleep = 1'b1;
    tick(3);
    chk({st.converter_on, st.active, smp, st.conversion_done_flag}, 4'h8);
    c = '0;
    tick(2);
    $display("sleep abort done");
  endtask
  task automatic t_trig();
    for (int s = 0; s < 34; s++) begin
      power_up(1'b0);
      c.trigger_select = s[5:0];
      trig[(s + 1) % 34] = 1'b1;
      tick(6);
      chk(st.go, 0);
      trig = 34'h0;
      tick(1);
      trig[s] = 1'b1;
      n = 0;
      while (st.go !== 1'b1 && n < 10) begin
        tick(1);
        n++;
      end
      chk(st.go, 1);
      trig = 34'h0;
      wait_done();
    end
    $display("trigger sources done");
  endtask
  task automatic t_reset();
    power_up(1'b0);
    go();
    tick(50);
    rst = 1'b1;
    c = '0;
    tick(1);
    chk({st, smp}, 0);
    rst = 1'b0;
    tick(3);
    chk({st, smp}, 0);
    $display("mid reset done");
  endtask

  // main sequence
  initial begin
    tick(5);
    rst = 1'b0;
    tick(2);
    t_full();
    t_off();
    t_stop();
    t_rc(1'b1);
    t_rc(1'b0);
    t_sleep_abort();
    t_trig();
    t_reset();
    results();
  end
endmodule
